//--- verilog/usp_map.svh
// Purpose: constants for the serial port block
// Assumes: 10 MHz core clock
// Notes:   offsets, counts and reset values only
`ifndef USP_MAP_SVH
`define USP_MAP_SVH

// Core clock rate in Hz
`define USP_CLK_HZ     10000000
// Oversampling ticks per asynchronous bit
`define USP_OSR        8
`define USP_OSR_LAST   3'h7
// Sample window of the majority filter
`define USP_SMP_FIRST  3'h3
`define USP_SMP_LAST   3'h5
// Character length limits and frame width
`define USP_MIN_BITS   4'h5
`define USP_MAX_BITS   4'h9
`define USP_SPI_BITS   4'h8
`define USP_SPI_LAST   4'h7
// Infrared pulse length and receive stretch, in ticks
`define USP_IR_PULSE   3'h2
`define USP_IR_HOLD    3'h6
`define USP_IR_MAX_BPS 115200
// Reset values
`define USP_RST_LINE   1'b1
`define USP_RST_DATA   9'h000
`define USP_RST_FRAME  13'h1FFF

`endif

//--- verilog/usp_pkg.sv
// Purpose: types shared by the serial port block
// Assumes: constants live in usp_map.svh
// Notes:   state encodings follow Gray order
package usp_pkg;

  // Operating mode of the port
  typedef enum logic [1:0]
  {
    USP_MODE_ASYNC    = 2'h0,
    USP_MODE_SYNC_MST = 2'h1,
    USP_MODE_SYNC_SLV = 2'h3,
    USP_MODE_SPI      = 2'h2
  } usp_mode_t;

  // Transmitter states
  typedef enum logic
  {
    USP_TX_IDLE  = 1'b0,
    USP_TX_SHIFT = 1'b1
  } usp_tx_state_t;

  // Receiver states
  typedef enum logic
  {
    USP_RX_IDLE = 1'b0,
    USP_RX_BITS = 1'b1
  } usp_rx_state_t;

endpackage : usp_pkg

//--- verilog/usp_baud.sv
// Purpose: fractional baud tick generator
// Assumes: div_int_i of zero acts as one
// Notes:   mean tick period is int + frac/16 clocks
`timescale 1ns/1ps
module usp_baud
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // Divider setting
  input  wire logic        run_i,
  input  wire logic [11:0] div_int_i,
  input  wire logic [3:0]  div_frac_i,
  // Tick out
  output logic             tick_o
);

  logic [11:0] cnt_reg;
  logic [3:0]  acc_reg;
  logic        extra_reg;
  logic [11:0] lim;
  logic [4:0]  acc_sum;

  // Period limit stretched by one when the fraction overflows
  always_comb
  begin
    lim     = ((div_int_i == 12'h000) ? 12'h000 : div_int_i - 12'h001) + {11'h000, extra_reg};
    acc_sum = {1'b0, acc_reg} + {1'b0, div_frac_i};
    tick_o  = run_i && (cnt_reg == lim);
  end

  // Cycle counter
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_reg <= 12'h000;
    else if (!run_i || tick_o)
      cnt_reg <= 12'h000;
    else
      cnt_reg <= cnt_reg + 12'h001;
  end

  // Fraction accumulator spreads the extra cycles evenly
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_reg   <= 4'h0;
      extra_reg <= 1'b0;
    end
    else if (!run_i)
    begin
      acc_reg   <= 4'h0;
      extra_reg <= 1'b0;
    end
    else if (tick_o)
    begin
      acc_reg   <= acc_sum[3:0];
      extra_reg <= acc_sum[4];
    end
  end

endmodule : usp_baud

//--- verilog/usp_top.sv
// Purpose: serial transceiver with SPI master mode
// Assumes: all inputs synchronous to clock_i
// Notes:   one baud tick shared by both directions
// Operation
// [RULE_01] Full duplex, asynchronous or synchronous mode
// [RULE_02] Sync clock max half, async eighth
// [RULE_03] Five to nine data bits, 1-2 stops
// [RULE_04] Fractional baud divider from any clock
// [RULE_05] Odd or even parity generated and checked
// [RULE_06] Framing error and overrun flagged separately
// [RULE_07] False start rejection and low-pass filter
// [RULE_08] Three interrupts: txc, dre, rxc
// [RULE_09] Multiprocessor mode drops unaddressed data frames
// [RULE_10] Buffered both ways, back-to-back frames
// [RULE_11] Sync slave takes clock from pin
// [RULE_12] SPI mode drops framing logic only
// [RULE_13] SPI double buffered, bit order, half clock
// [RULE_14] Pins and interrupts same in both modes
// [RULE_15] Infrared pulse codec up to 115.2 kbps
// [RULE_16] Three pins: clock, receive, transmit
// [RULE_17] Oversampled receive, centre samples, confirmed start
`timescale 1ns/1ps
`include "usp_map.svh"
module usp_top
(
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               arst_n_i,
  // Configuration
  input  wire logic               tx_en_i,
  input  wire logic               rx_en_i,
  input  wire usp_pkg::usp_mode_t mode_i,
  input  wire logic [3:0]         char_bits_i,
  input  wire logic               stop2_i,
  input  wire logic               par_en_i,
  input  wire logic               par_odd_i,
  input  wire logic               mpcm_i,
  input  wire logic               lsb_first_i,
  input  wire logic               infrared_pulse_codec_en_i,
  input  wire logic [11:0]        baud_int_i,
  input  wire logic [3:0]         baud_frac_i,
  // Transmit data
  input  wire logic [8:0]         tx_data_i,
  input  wire logic               tx_wr_i,
  input  wire logic               txc_clr_i,
  // Receive data
  input  wire logic               rx_rd_i,
  output logic [8:0]              rx_data_o,
  output logic                    rx_ferr_o,
  output logic                    rx_perr_o,
  output logic                    rx_ovf_o,
  // Interrupt requests
  output logic                    irq_txc_o,
  output logic                    irq_dre_o,
  output logic                    irq_rxc_o,
  // Pins
  input  wire logic               xfer_clock_pin_i,
  output logic                    xfer_clock_pin_o,
  output logic                    xfer_clock_pin_oe_n_o,
  input  wire logic               rx_data_pin_i,
  output logic                    tx_data_pin_o,
  output logic                    tx_data_pin_oe_n_o
);
  import usp_pkg::*;

  // Clamp the character length into the legal range
  function automatic logic [3:0] char_len(input logic [3:0] c);
    if (c < `USP_MIN_BITS)
      return `USP_MIN_BITS;
    else if (c > `USP_MAX_BITS)
      return `USP_MAX_BITS;
    return c;
  endfunction : char_len

  // Parity over the low n bits; odd starts from one
  function automatic logic calc_par(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        p = p ^ d[i];
    return p;
  endfunction : calc_par

  // Whole frame, start bit in bit 0, idle ones above
  function automatic logic [12:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                              input logic pe, input logic odd);
    logic [12:0] f;
    f    = `USP_RST_FRAME;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        f[i + 1] = d[i];
    if (pe)
      f[n + 4'h1] = calc_par(d, n, odd);
    return f;
  endfunction : build_frame

  // Bit reversal of a byte for MSB-first SPI
  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = d[7 - i];
    return r;
  endfunction : rev8

  // Declarations
  logic          tick;
  logic [3:0]    nbits;
  logic          is_spi;
  logic          is_async;
  logic          is_master;
  logic          xck_reg;
  logic          xck_prev_reg;
  logic          rise_ev;
  logic          fall_ev;
  usp_tx_state_t tx_state_reg;
  logic [8:0]    tx_buf_reg;
  logic          tx_full_reg;
  logic [12:0]   tx_sh_reg;
  logic [3:0]    tx_left_reg;
  logic [2:0]    tx_os_reg;
  logic          txc_reg;
  logic          tx_pin_reg;
  logic          tx_busy;
  logic          tx_bit_end;
  logic          tx_last;
  logic          tx_load;
  logic [3:0]    tx_len;
  usp_rx_state_t rx_state_reg;
  logic [2:0]    rx_os_reg;
  logic [2:0]    rx_smp_reg;
  logic [3:0]    rx_idx_reg;
  logic [8:0]    rx_sh_reg;
  logic          rx_perr_reg;
  logic [8:0]    rx_buf_reg;
  logic          rx_full_reg;
  logic          rx_ferr_reg;
  logic          rx_perrb_reg;
  logic          rx_ovf_reg;
  logic [2:0]    ir_cnt_reg;
  logic          rx_line;
  logic          rx_maj;
  logic          rx_bit_ev;
  logic          rx_bit_val;
  logic [3:0]    rx_stop_idx;
  logic          rx_done;
  logic          spi_done;
  logic          rx_addr;
  logic          rx_deliver;
  logic [7:0]    spi_word;
  logic [8:0]    rx_word;

  // Fractional baud tick, at most one per clock
  usp_baud u_baud
  (
    .clock_i    (clock_i),
    .arst_n_i   (arst_n_i),
    .run_i      (tx_en_i | rx_en_i),
    .div_int_i  (baud_int_i),
    .div_frac_i (baud_frac_i),
    .tick_o     (tick)
  ); // see [RULE_04]

  // Mode decode
  assign nbits     = char_len(char_bits_i); // see [RULE_03]
  assign is_spi    = (mode_i == USP_MODE_SPI);
  assign is_async  = (mode_i == USP_MODE_ASYNC); // see [RULE_01]
  assign is_master = (mode_i == USP_MODE_SYNC_MST) || is_spi;
  assign tx_busy   = (tx_state_reg == USP_TX_SHIFT);

  // Clock edges: own divided clock, or the remote one
  always_comb
  begin
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    if (is_master)
    begin
      rise_ev = tick && tx_busy && !xck_reg; // see [RULE_02]
      fall_ev = tick && tx_busy && xck_reg;
    end
    else if (mode_i == USP_MODE_SYNC_SLV)
    begin
      rise_ev = xfer_clock_pin_i && !xck_prev_reg; // see [RULE_11]
      fall_ev = !xfer_clock_pin_i && xck_prev_reg;
    end
  end

  // Master clock toggles each tick while a frame shifts
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      xck_reg      <= 1'b0;
      xck_prev_reg <= 1'b0;
    end
    else
    begin
      xck_prev_reg <= xfer_clock_pin_i;
      if (!is_master || !tx_busy)
        xck_reg <= 1'b0;
      else if (tick)
        xck_reg <= !xck_reg; // see [RULE_13]
    end
  end

  // Transmit bit boundaries
  assign tx_bit_end = is_async ? (tick && tx_busy && (tx_os_reg == `USP_OSR_LAST)) : fall_ev;
  assign tx_last    = tx_bit_end && (tx_left_reg == 4'h1);
  // Next frame loads on the last bit edge, so no idle gap
  assign tx_load    = tx_en_i && tx_full_reg && (!tx_busy || tx_last); // see [RULE_10]
  assign tx_len     = 4'h2 + nbits + {3'h0, par_en_i} + {3'h0, stop2_i}; // see [RULE_03]

  // Transmit holding buffer; a write while full is dropped
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_buf_reg  <= `USP_RST_DATA;
      tx_full_reg <= 1'b0;
    end
    else if (tx_wr_i && !tx_full_reg && tx_en_i)
    begin
      tx_buf_reg  <= tx_data_i;
      tx_full_reg <= 1'b1;
    end
    else if (tx_load || !tx_en_i)
      tx_full_reg <= 1'b0;
  end

  // Transmit shifter
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_state_reg <= USP_TX_IDLE;
      tx_sh_reg    <= `USP_RST_FRAME;
      tx_left_reg  <= 4'h0;
    end
    else if (!tx_en_i)
    begin
      tx_state_reg <= USP_TX_IDLE;
      tx_sh_reg    <= `USP_RST_FRAME;
      tx_left_reg  <= 4'h0;
    end
    else if (tx_load)
    begin
      tx_state_reg <= USP_TX_SHIFT;
      if (is_spi)
      begin
        // No start, parity or stop bits in SPI
        tx_sh_reg   <= {5'h1F, lsb_first_i ? tx_buf_reg[7:0] : rev8(tx_buf_reg[7:0])}; // see [RULE_12]
        tx_left_reg <= `USP_SPI_BITS; // see [RULE_13]
      end
      else
      begin
        tx_sh_reg   <= build_frame(tx_buf_reg, nbits, par_en_i, par_odd_i); // see [RULE_05]
        tx_left_reg <= tx_len;
      end
    end
    else if (tx_last)
    begin
      tx_state_reg <= USP_TX_IDLE;
      tx_sh_reg    <= `USP_RST_FRAME;
      tx_left_reg  <= 4'h0;
    end
    else if (tx_bit_end)
    begin
      tx_sh_reg   <= {1'b1, tx_sh_reg[12:1]};
      tx_left_reg <= tx_left_reg - 4'h1;
    end
  end

  // Oversample phase within a transmitted bit
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tx_os_reg <= 3'h0;
    else if (!tx_busy || tx_load)
      tx_os_reg <= 3'h0;
    else if (tick)
      tx_os_reg <= tx_os_reg + 3'h1;
  end

  // Complete flag; a new set beats a clear in the same cycle
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      txc_reg <= 1'b0;
    else if (tx_last && !tx_full_reg)
      txc_reg <= 1'b1; // see [RULE_08]
    else if (txc_clr_i)
      txc_reg <= 1'b0;
  end

  // Transmit pin; the infrared codec sends a zero as a short low pulse
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tx_pin_reg <= `USP_RST_LINE;
    else if (infrared_pulse_codec_en_i && is_async)
      tx_pin_reg <= tx_sh_reg[0] || (tx_os_reg >= `USP_IR_PULSE); // see [RULE_15]
    else
      tx_pin_reg <= tx_sh_reg[0];
  end

  // Infrared receive: stretch a short pulse over most of the bit
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ir_cnt_reg <= 3'h0;
    else if (infrared_pulse_codec_en_i && !rx_data_pin_i)
      ir_cnt_reg <= `USP_IR_HOLD; // see [RULE_15]
    else if (tick && (ir_cnt_reg != 3'h0))
      ir_cnt_reg <= ir_cnt_reg - 3'h1;
  end

  // Receive line, bit events and frame end decode
  always_comb
  begin
    rx_line     = (infrared_pulse_codec_en_i && is_async) ? (rx_data_pin_i && (ir_cnt_reg == 3'h0)) : rx_data_pin_i;
    // Majority of three centre samples is the low-pass filter
    rx_maj      = (rx_smp_reg[0] & rx_smp_reg[1]) | (rx_smp_reg[0] & rx_smp_reg[2]) |
                  (rx_smp_reg[1] & rx_smp_reg[2]); // see [RULE_07]
    rx_bit_ev   = 1'b0;
    rx_bit_val  = rx_line;
    if (rx_state_reg == USP_RX_BITS)
    begin
      if (is_async)
      begin
        rx_bit_ev  = tick && (rx_os_reg == `USP_OSR_LAST); // see [RULE_17]
        rx_bit_val = rx_maj;
      end
      else if (!is_spi)
        rx_bit_ev = rise_ev;
    end
    rx_stop_idx = nbits + 4'h1 + {3'h0, par_en_i};
    rx_done     = !is_spi && rx_bit_ev && (rx_idx_reg == rx_stop_idx);
    spi_done    = is_spi && rise_ev && (rx_idx_reg == `USP_SPI_LAST);
    // Address marker: ninth bit, else first stop bit
    rx_addr     = (nbits == `USP_MAX_BITS) ? rx_sh_reg[8] : rx_bit_val;
    rx_deliver  = (rx_done && !(mpcm_i && !rx_addr)) || spi_done; // see [RULE_09]
    spi_word    = lsb_first_i ? {rx_line, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], rx_line};
    rx_word     = is_spi ? {1'b0, spi_word} : rx_sh_reg;
  end

  // Receive state machine and shifter
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_state_reg <= USP_RX_IDLE;
      rx_os_reg    <= 3'h0;
      rx_smp_reg   <= 3'h7;
      rx_idx_reg   <= 4'h0;
      rx_sh_reg    <= `USP_RST_DATA;
      rx_perr_reg  <= 1'b0;
    end
    else if (!rx_en_i)
    begin
      rx_state_reg <= USP_RX_IDLE;
      rx_idx_reg   <= 4'h0;
    end
    else if (is_spi)
    begin
      // Receive shifts with the transmit clock
      rx_state_reg <= USP_RX_IDLE;
      if (rise_ev)
      begin
        rx_sh_reg[7:0] <= spi_word;
        rx_idx_reg     <= spi_done ? 4'h0 : rx_idx_reg + 4'h1;
      end
      else if (!tx_busy)
        rx_idx_reg <= 4'h0;
    end
    else
    begin
      case (rx_state_reg)
        USP_RX_IDLE:
        begin
          if (is_async ? (tick && !rx_line) : (rise_ev && !rx_line))
          begin
            rx_state_reg <= USP_RX_BITS;
            rx_sh_reg    <= `USP_RST_DATA;
            rx_perr_reg  <= 1'b0;
            rx_os_reg    <= 3'h1;
            rx_smp_reg   <= 3'h7;
            // Synchronous start bit is taken on the spot
            rx_idx_reg   <= is_async ? 4'h0 : 4'h1;
          end
        end
        USP_RX_BITS:
        begin
          if (is_async && tick)
          begin
            rx_os_reg <= rx_os_reg + 3'h1;
            if ((rx_os_reg >= `USP_SMP_FIRST) && (rx_os_reg <= `USP_SMP_LAST))
              rx_smp_reg <= {rx_smp_reg[1:0], rx_line}; // see [RULE_17]
          end
          if (rx_bit_ev)
          begin
            if ((rx_idx_reg == 4'h0) && rx_bit_val)
              rx_state_reg <= USP_RX_IDLE; // see [RULE_07]
            else if (rx_idx_reg == rx_stop_idx)
              rx_state_reg <= USP_RX_IDLE;
            else
            begin
              if ((rx_idx_reg != 4'h0) && (rx_idx_reg <= nbits))
                rx_sh_reg[rx_idx_reg - 4'h1] <= rx_bit_val;
              if (par_en_i && (rx_idx_reg == nbits + 4'h1))
                rx_perr_reg <= rx_bit_val != calc_par(rx_sh_reg, nbits, par_odd_i); // see [RULE_05]
              rx_idx_reg <= rx_idx_reg + 4'h1;
            end
          end
        end
        default:
          rx_state_reg <= USP_RX_IDLE;
      endcase
    end
  end

  // Receive buffer; a new frame beats a read in the same cycle
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_buf_reg   <= `USP_RST_DATA;
      rx_full_reg  <= 1'b0;
      rx_ferr_reg  <= 1'b0;
      rx_perrb_reg <= 1'b0;
    end
    else if (rx_deliver && (!rx_full_reg || rx_rd_i))
    begin
      rx_buf_reg   <= rx_word; // see [RULE_10]
      rx_full_reg  <= 1'b1;
      // Frame checks are off in SPI mode
      rx_ferr_reg  <= !is_spi && !rx_bit_val && !(mpcm_i && (nbits != `USP_MAX_BITS)); // see [RULE_06]
      rx_perrb_reg <= !is_spi && rx_perr_reg;
    end
    else if (rx_rd_i)
      rx_full_reg <= 1'b0;
  end

  // Overrun: frame lost because the buffer was still full
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rx_ovf_reg <= 1'b0;
    else if (rx_deliver && rx_full_reg && !rx_rd_i)
      rx_ovf_reg <= 1'b1; // see [RULE_06]
    else if (rx_rd_i)
      rx_ovf_reg <= 1'b0;
  end

  // Data and status outputs straight from flip-flops
  assign rx_data_o = rx_buf_reg;
  assign rx_ferr_o = rx_ferr_reg;
  assign rx_perr_o = rx_perrb_reg;
  assign rx_ovf_o  = rx_ovf_reg;

  // Interrupt levels, same in frame and SPI modes
  assign irq_txc_o = txc_reg; // see [RULE_14]
  assign irq_dre_o = tx_en_i && !tx_full_reg; // see [RULE_08]
  assign irq_rxc_o = rx_full_reg;

  // Pin drivers; enables are low while driving
  assign tx_data_pin_o         = tx_pin_reg; // see [RULE_16]
  assign tx_data_pin_oe_n_o    = !tx_en_i;
  assign xfer_clock_pin_o      = xck_reg;
  assign xfer_clock_pin_oe_n_o = !(is_master && (tx_en_i || rx_en_i)); // see [RULE_14]

endmodule : usp_top

//--- sim/usp_top_properties.sv
// Purpose: port checks for the serial port block
// Assumes: refill bound holds for a one-clock tick
// Notes:   bound to usp_top after the module
`timescale 1ns/1ps
module usp_top_properties
(
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        arst_n_i,
  // Inputs watched
  input wire logic        tx_en_i,
  input wire logic [1:0]  mode_i,
  input wire logic        infrared_pulse_codec_en_i,
  input wire logic [11:0] baud_int_i,
  input wire logic [3:0]  baud_frac_i,
  input wire logic        tx_wr_i,
  input wire logic        txc_clr_i,
  input wire logic        rx_rd_i,
  // Outputs watched
  input wire logic        rx_ferr_o,
  input wire logic        rx_ovf_o,
  input wire logic        irq_txc_o,
  input wire logic        irq_dre_o,
  input wire logic        irq_rxc_o,
  input wire logic        xfer_clock_pin_oe_n_o,
  input wire logic        tx_data_pin_o,
  input wire logic        tx_data_pin_oe_n_o
);
  import usp_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // Flags and pins tied to their causes
  chk_dre_needs_en: assert property (!tx_en_i |-> !irq_dre_o)
    else $error("dre while off");
  chk_tx_pin_oe: assert property (tx_data_pin_oe_n_o == !tx_en_i)
    else $error("tx oe wrong");
  chk_bit_width: assert property ($changed(tx_data_pin_o) && tx_en_i && !infrared_pulse_codec_en_i && mode_i == USP_MODE_ASYNC
    |=> ($stable(tx_data_pin_o) || !tx_en_i) [*7])
    else $error("short async bit");
  // Guard: bound holds for one-clock tick
  chk_dre_refill: assert property (tx_wr_i && irq_dre_o && tx_en_i && baud_int_i == 12'h001 && baud_frac_i == 4'h0
    |-> ##[1:300] (irq_dre_o || !tx_en_i))
    else $error("dre late");
  chk_rxc_hold: assert property ($fell(irq_rxc_o) |-> $past(rx_rd_i))
    else $error("rxc fell unread");
  chk_txc_hold: assert property ($fell(irq_txc_o) |-> $past(txc_clr_i))
    else $error("txc fell uncleared");
  chk_ovf_sticky: assert property ($fell(rx_ovf_o) |-> $past(rx_rd_i))
    else $error("ovf fell unread");
  chk_ferr_word: assert property ($rose(rx_ferr_o) |-> irq_rxc_o)
    else $error("ferr without word");
  chk_xck_async: assert property ((mode_i == USP_MODE_ASYNC) [*2] |-> xfer_clock_pin_oe_n_o)
    else $error("xck driven in async");
endmodule : usp_top_properties

bind usp_top usp_top_properties i_usp_top_properties (.*);

//--- sim/usp_remote.sv
// Purpose: remote serial device on the data pins
// Assumes: eight clocks a bit
// Notes:   decodes the block's frames, sends its own
`timescale 1ns/1ps
module usp_remote
(
  // Clock
  input  wire logic clock_i,
  // Lines
  input  wire logic tx_line_i,
  output logic      rx_line_o
);
  logic [8:0] got_word;
  logic       got_par;
  logic       got_stop;
  int         got_cnt = 0;
  int         nbits   = 8;
  logic       par_on  = 1'h0;
  time        st0, st1;

  initial rx_line_o = 1'h1;

  // Frame out, LSB first; bad forces a zero stop bit
  task automatic send(input logic [8:0] d, input int n, input logic pe, po, bad);
    logic q[$];
    logic p;
    p = po;
    q.push_back(1'h0);
    for (int i = 0; i < n; i++)
    begin
      q.push_back(d[i]);
      p ^= d[i];
    end
    if (pe) q.push_back(p);
    q.push_back(!bad);
    foreach (q[i])
    begin
      @(posedge clock_i);
      rx_line_o <= q[i];
      repeat (7) @(posedge clock_i);
    end
    @(posedge clock_i);
    rx_line_o <= 1'h1;
  endtask : send

  // Short low spike, too brief to be a start bit
  task automatic glitch(input int n);
    @(posedge clock_i);
    rx_line_o <= 1'h0;
    repeat (n) @(posedge clock_i);
    rx_line_o <= 1'h1;
  endtask : glitch

  // Mid-bit sampling; start times kept to measure gaps
  always
  begin : rx_dec
    logic [8:0] w;
    @(negedge tx_line_i);
    st0 = st1;
    st1 = $time;
    w = '0;
    repeat (4) @(posedge clock_i);
    for (int i = 0; i < nbits; i++)
    begin
      repeat (8) @(posedge clock_i);
      w[i] = tx_line_i;
    end
    if (par_on)
    begin
      repeat (8) @(posedge clock_i);
      got_par = tx_line_i;
    end
    repeat (8) @(posedge clock_i);
    got_stop = tx_line_i;
    got_word = w;
    got_cnt++;
  end
endmodule : usp_remote

//--- sim/usp_top_tb_top.sv
// Purpose: self-checking bench for the serial port
// Assumes: one-clock baud tick throughout
// Notes:   remote device model on the data pins
`timescale 1ns/1ps
module usp_top_tb_top;
  import usp_pkg::*;
  logic        clock_i, arst_n_i, tx_en_i, rx_en_i, stop2_i, par_en_i, par_odd_i;
  logic        mpcm_i, lsb_first_i, infrared_pulse_codec_en_i, tx_wr_i, txc_clr_i, rx_rd_i;
  usp_mode_t   mode_i;
  logic [3:0]  char_bits_i, baud_frac_i;
  logic [11:0] baud_int_i;
  logic [8:0]  tx_data_i, rx_data_o;
  logic        rx_ferr_o, rx_perr_o, rx_ovf_o, irq_txc_o, irq_dre_o, irq_rxc_o;
  logic        xck_o, xck_oe_n, tx_pin, tx_oe_n, rx_pin;
  wire         xck_wire = xck_oe_n ? 1'h0 : xck_o; // Pull-down when undriven
  wire         tx_wire  = tx_oe_n ? 1'h1 : tx_pin; // Pull-up on released line
  int          err_count = 0, num_checks = 0, cyc = 0;

  usp_top i_usp_top
  (
    .*,
    .xfer_clock_pin_i(xck_wire), .xfer_clock_pin_o(xck_o), .xfer_clock_pin_oe_n_o(xck_oe_n),
    .rx_data_pin_i(rx_pin), .tx_data_pin_o(tx_pin), .tx_data_pin_oe_n_o(tx_oe_n)
  );
  usp_remote i_usp_remote (.clock_i, .tx_line_i(tx_wire), .rx_line_o(rx_pin));

  // Clock, 100 ns period
  initial
  begin
    clock_i = 1'h0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic cmp_word(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({8'h00, got}, {8'h00, exp});
  endtask : cmp_bit

  // Bounded wait on a flag: 0 empty, 1 receive, 2 complete
  task automatic wait_hi(input int k);
    logic s;
    repeat (400)
    begin
      @(negedge clock_i);
      s = (k == 0) ? irq_dre_o : (k == 1) ? irq_rxc_o : irq_txc_o;
      if (s === 1'h1) break;
    end
    cmp_bit(s, 1'h1);
  endtask : wait_hi

  task automatic got(input int n, input logic [8:0] e);
    repeat (400)
    begin
      @(negedge clock_i);
      if (i_usp_remote.got_cnt >= n) break;
    end
    cmp_word(i_usp_remote.got_word, e);
  endtask : got

  task automatic pulse(input int k);
    @(posedge clock_i);
    if (k == 0) rx_rd_i <= 1'h1;
    else txc_clr_i <= 1'h1;
    @(posedge clock_i);
    rx_rd_i <= 1'h0;
    txc_clr_i <= 1'h0;
    @(negedge clock_i);
  endtask : pulse

  // Write waits for the empty flag; refused writes are not tried
  task automatic wr(input logic [8:0] d);
    wait_hi(0);
    @(posedge clock_i);
    tx_wr_i <= 1'h1;
    tx_data_i <= d;
    @(posedge clock_i);
    tx_wr_i <= 1'h0;
  endtask : wr

  task automatic cfg(input usp_mode_t m, input logic [3:0] n, input logic pe, po, s2, mp);
    @(posedge clock_i);
    mode_i <= m;
    char_bits_i <= n;
    par_en_i <= pe;
    par_odd_i <= po;
    stop2_i <= s2;
    mpcm_i <= mp;
    i_usp_remote.nbits = n;
    i_usp_remote.par_on = pe;
  endtask : cfg

  task automatic t_tx;
    cfg(USP_MODE_ASYNC, 4'h8, 1'h0, 1'h0, 1'h0, 1'h0);
    tx_en_i <= 1'h1;
    wr(9'h0A5);
    wr(9'h03C);
    got(1, 9'h0A5);
    got(2, 9'h03C);
    cmp_word(9'((i_usp_remote.st1 - i_usp_remote.st0) / 100), 9'h050);
    wait_hi(2);
    pulse(1);
    cmp_bit(irq_txc_o, 1'h0);
    cfg(USP_MODE_ASYNC, 4'h9, 1'h1, 1'h1, 1'h1, 1'h0);
    wr(9'h1C3);
    got(3, 9'h1C3);
    cmp_bit(i_usp_remote.got_par, 1'h0);
    cmp_bit(i_usp_remote.got_stop, 1'h1);
  endtask : t_tx

  // One received frame with its expected flags, then a read
  task automatic rx_one(input logic [8:0] d, input logic po, bad, pe_exp);
    i_usp_remote.send(d, 8, 1'h1, po, bad);
    wait_hi(1);
    cmp_word(rx_data_o, d);
    cmp_bit(rx_perr_o, pe_exp);
    cmp_bit(rx_ferr_o, bad);
    pulse(0);
  endtask : rx_one

  task automatic t_rx;
    cfg(USP_MODE_ASYNC, 4'h8, 1'h1, 1'h0, 1'h0, 1'h0);
    fork
      rx_one(9'h05A, 1'h0, 1'h0, 1'h0);
      wr(9'h0F0);
    join
    got(4, 9'h0F0);
    rx_one(9'h05A, 1'h1, 1'h0, 1'h1);
    rx_one(9'h033, 1'h0, 1'h1, 1'h0);
    i_usp_remote.send(9'h011, 8, 1'h1, 1'h0, 1'h0);
    i_usp_remote.send(9'h022, 8, 1'h1, 1'h0, 1'h0);
    repeat (4) @(negedge clock_i);
    cmp_bit(rx_ovf_o, 1'h1);
    cmp_word(rx_data_o, 9'h011);
    pulse(0);
    cmp_bit(rx_ovf_o, 1'h0);
    cmp_bit(irq_rxc_o, 1'h0);
    i_usp_remote.glitch(2);
    repeat (100) @(negedge clock_i);
    cmp_bit(irq_rxc_o, 1'h0);
  endtask : t_rx

  task automatic t_mpcm;
    cfg(USP_MODE_ASYNC, 4'h9, 1'h0, 1'h0, 1'h0, 1'h1);
    i_usp_remote.send(9'h055, 9, 1'h0, 1'h0, 1'h0);
    repeat (20) @(negedge clock_i);
    cmp_bit(irq_rxc_o, 1'h0);
    i_usp_remote.send(9'h1AB, 9, 1'h0, 1'h0, 1'h0);
    wait_hi(1);
    cmp_word(rx_data_o, 9'h1AB);
    pulse(0);
  endtask : t_mpcm

  // Bits taken on each rising transfer clock, MSB first
  task automatic t_spi;
    logic [8:0] w    = '0;
    logic       prev = 1'h0;
    int         k    = 0;
    cfg(USP_MODE_SPI, 4'h8, 1'h0, 1'h0, 1'h0, 1'h0);
    wr(9'h0C5);
    for (int i = 0; i < 200 && k < 8; i++)
    begin
      @(negedge clock_i);
      if (xck_wire && !prev)
      begin
        w = {w[7:0], tx_wire};
        k++;
      end
      prev = xck_wire;
    end
    cmp_word(w, 9'h0C5);
    cmp_bit(xck_oe_n, 1'h0);
    wait_hi(1);
    cmp_word(rx_data_o, 9'h0FF);
  endtask : t_spi

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Hang guard, well above the expected thousand or so cycles
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    {arst_n_i, tx_en_i, stop2_i, par_en_i, par_odd_i, mpcm_i, lsb_first_i} = '0;
    {infrared_pulse_codec_en_i, tx_wr_i, txc_clr_i, rx_rd_i, baud_frac_i} = '0;
    rx_en_i = 1'h1;
    mode_i = USP_MODE_ASYNC;
    char_bits_i = 4'h8;
    baud_int_i = 12'h001;
    tx_data_i = 9'h000;
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'h1;
    @(negedge clock_i);
    cmp_bit(irq_dre_o, 1'h0);
    cmp_bit(tx_wire, 1'h1);
    cmp_word(rx_data_o, 9'h000);
    t_tx();
    t_rx();
    t_mpcm();
    t_spi();
    wrap_up();
  end
endmodule : usp_top_tb_top
